// File: common/rpw_defs.vh
`ifndef RPW_DEFS_VH
`define RPW_DEFS_VH
// Command code of the hold-time parameter
`define RPW_CMD_HOLD_TIME 8'h22
// Hold-time reset value, settable maximum and the never-expire value
`define RPW_HOLD_RESET 8'h00
`define RPW_HOLD_MAX 8'h7f
`define RPW_HOLD_FOREVER 8'hff
// Hold-time unit in ms and clock period in ns
`define RPW_HOLD_UNIT_MS 100
`define RPW_CLK_PERIOD_NS 10
// Hold-time unit in clock cycles
`define RPW_HOLD_UNIT_CYC (`RPW_HOLD_UNIT_MS * 1000000 / `RPW_CLK_PERIOD_NS)
// Pulse step length in ns and steps per period
`define RPW_STEP_NS 208000
`define RPW_STEP_CYC (`RPW_STEP_NS / `RPW_CLK_PERIOD_NS)
`define RPW_STEPS 40
// Largest high time in steps, 95 percent of 40
`define RPW_MAX_HIGH 38
// Strength code range
`define RPW_CODE_MIN 8'h06
`define RPW_CODE_MAX 8'h36
// Codes per 10 dB and steps added per 10 dB
`define RPW_CODES_PER_10DB 10
`define RPW_STEPS_PER_10DB 6
// High steps at 10 dB above sensitivity (47.5 percent)
`define RPW_HIGH_AT_10DB 19
`endif

// File: hdl/rpw_map.v
`include "rpw_defs.vh"
// Maps a strength code to a count of high steps
module rpw_map (
  input wire [7:0] code,
  output reg [5:0] high_steps
);
  reg [7:0] above; // Codes above sensitivity
  reg [10:0] steps; // Unclamped high steps, wide enough for any code
  // Map constants at the width of the sum; CLAMP_STEPS at the output width
  localparam [10:0] SLOPE = `RPW_STEPS_PER_10DB;
  localparam [10:0] SPAN = `RPW_CODES_PER_10DB;
  localparam [10:0] BASE = `RPW_HIGH_AT_10DB - `RPW_STEPS_PER_10DB;
  localparam [10:0] CLAMP = `RPW_MAX_HIGH;
  localparam [5:0] CLAMP_STEPS = `RPW_MAX_HIGH;
  // Linear map anchored at 10 dB, clamped to 0..38
  always @* begin
    above = 8'h00;
    steps = 11'h000;
    high_steps = 6'h00;
    if (code > `RPW_CODE_MIN) begin
      above = code - `RPW_CODE_MIN;
      // Slope of six steps per ten codes; anchor gives 19 at 10 dB
      steps = ({3'b000, above} * SLOPE) / SPAN + BASE; // RL8 RL17
      if (steps > CLAMP) begin
        high_steps = CLAMP_STEPS; // RL6
      end else begin
        high_steps = steps[5:0];
      end
    end else begin
      high_steps = 6'h00; // RL7
    end
  end
endmodule // rpw_map

// File: hdl/rpw_indicator.v
// Overview of operation
// RL1 - Hold time in 100 ms units, 0..0x7F
// RL2 - Hold time resets zero; zero disables output
// RL3 - Hold time via command 0x22, one byte
// RL4 - Pulse period is 8.32 ms
// RL5 - Forty steps of 0.208 ms each
// RL6 - High fraction limited to 95 percent
// RL7 - Zero high time at or below sensitivity
// RL8 - 47.5, 62.5, 77.5 percent at 10/20/30 dB
// RL9 - Output shows last strength for hold time
// RL10 - Expired hold time keeps output low
// RL11 - Output low after power-up until packet
// RL12 - Value 0xFF never times out
// RL13 - Pin input at power-up, sampled for command mode
// RL14 - Nonzero hold: pin driven low until packet
// RL15 - Pin stays input for hold time after power-up
// RL16 - Strength code 0x06..0x36, larger is stronger
// RL17 - Six steps per 10 dB, clamped
// RL18 - Packet restarts timer; duty changes at boundary
`include "rpw_defs.vh"
module rpw_indicator #(
  parameter UNIT_CYC = `RPW_HOLD_UNIT_CYC,
  parameter STEP_CYC = `RPW_STEP_CYC
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Command port
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_wdata,
  output reg cmd_rvalid_r,
  output reg [7:0] cmd_rdata_r,
  // Received packet strength
  input wire pkt_valid,
  input wire [7:0] pkt_code,
  // Shared pin
  input wire pin_in,
  output reg pin_out_r,
  output reg pin_oe_r,
  // Status
  output reg cmd_mode_r,
  output reg [7:0] hold_time_r
);
  // Power-up phases
  localparam PH_SAMPLE = 2'd0;
  localparam PH_WAIT = 2'd1;
  localparam PH_RUN = 2'd2;
  // Last step index of a period
  localparam [5:0] LAST_STEP = `RPW_STEPS - 1;
  // Sample-phase count at which both synchroniser stages hold the pin
  localparam [1:0] SAMPLE_AT = 2'd2;
  // Hold value that never times out
  localparam [7:0] HOLD_FOREVER = `RPW_HOLD_FOREVER;
  // Pin synchroniser and power-up state
  reg pin_s1_r; // Synchroniser stage one
  reg pin_s2_r; // Synchronised pin
  reg [1:0] phase_r; // Power-up phase
  reg [1:0] boot_cnt_r; // Edges spent in the sample phase
  // Hold timing
  reg [31:0] unit_cnt_r; // Cycles inside a 100 ms unit
  reg [7:0] units_r; // Units elapsed
  // Duty path
  reg active_r; // Strength display active
  reg seen_r; // A packet has arrived
  reg [5:0] pend_r; // Duty waiting for next boundary
  reg [5:0] duty_r; // Duty used this period
  reg [31:0] step_cnt_r; // Cycles inside a step
  reg [5:0] step_r; // Step index within a period
  wire [5:0] mapped; // Mapped high steps
  wire unit_tick = (unit_cnt_r == UNIT_CYC - 1);
  wire step_tick = (step_cnt_r == STEP_CYC - 1);
  wire enabled = (hold_time_r != 8'h00);
  // Hold-time command addressed to this block
  wire cmd_hit = cmd_valid && (cmd_code == `RPW_CMD_HOLD_TIME);
  // Packets count only once the pin is ours
  wire pkt_take = pkt_valid && (phase_r == PH_RUN);
  // Hold has run out since the last packet; the never-expire code is exempt
  wire expired = (hold_time_r != HOLD_FOREVER) && (units_r >= hold_time_r) && seen_r;
  // High for the first duty steps of each period while driving
  wire high_now = (phase_r == PH_RUN) && enabled && (step_r < duty_r);
  // Strength to duty map
  rpw_map u_map (
    .code(pkt_code), // RL16
    .high_steps(mapped)
  );
  // Two-flop synchroniser for the shared pin
  // Only the second stage is read; sampling waits for it to fill
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end
  // Command port: hold-time read and write
  // Out-of-range writes are dropped silently
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_time_r <= `RPW_HOLD_RESET; // RL2
      cmd_rvalid_r <= 1'b0;
      cmd_rdata_r <= 8'h00;
    end else begin
      cmd_rvalid_r <= 1'b0;
      if (cmd_hit) begin // RL3
        if (cmd_write) begin
          // Accept 0..0x7F and the never-expire code
          if (cmd_wdata <= `RPW_HOLD_MAX || cmd_wdata == `RPW_HOLD_FOREVER) begin // RL1 RL12
            hold_time_r <= cmd_wdata;
          end
        end else begin
          // Read answers on the next edge
          cmd_rvalid_r <= 1'b1; // RL3
          cmd_rdata_r <= hold_time_r;
        end
      end
    end
  end
  // Unit timer, shared by power-up wait and hold timeout
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      unit_cnt_r <= 32'h0;
      units_r <= 8'h00;
    end else if (pkt_take) begin
      // A taken packet restarts the hold count
      unit_cnt_r <= 32'h0; // RL18
      units_r <= 8'h00;
    end else if (unit_tick) begin
      unit_cnt_r <= 32'h0;
      // Saturate so a long wait never wraps below the hold
      if (units_r != 8'hff) begin
        units_r <= units_r + 8'h01;
      end
    end else begin
      // Count cycles inside the unit
      unit_cnt_r <= unit_cnt_r + 32'h1;
    end
  end
  // Power-up sequencing of the shared pin
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= PH_SAMPLE;
      cmd_mode_r <= 1'b0;
      pin_oe_r <= 1'b0; // RL13
      boot_cnt_r <= 2'd0;
    end else begin
      case (phase_r)
        PH_SAMPLE: begin
          // Wait until the synchroniser holds the real pin level
          if (boot_cnt_r == SAMPLE_AT) begin
            // Low on the pin asks for command mode
            cmd_mode_r <= ~pin_s2_r; // RL13
            phase_r <= PH_WAIT;
          end else begin
            boot_cnt_r <= boot_cnt_r + 2'd1;
          end
        end
        PH_WAIT: begin
          // Pin stays released for the hold time
          if (enabled && units_r >= hold_time_r) begin // RL15
            phase_r <= PH_RUN;
            pin_oe_r <= 1'b1; // RL14
          end
        end
        PH_RUN: begin
          // Clearing the hold releases the pin at once
          pin_oe_r <= enabled; // RL2
        end
        default: begin
          // Unused code falls back to sampling
          phase_r <= PH_SAMPLE;
        end
      endcase
    end
  end
  // Packet capture and hold expiry
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_r <= 1'b0; // RL11
      seen_r <= 1'b0;
      pend_r <= 6'h00;
    end else if (pkt_take) begin
      // A packet in the same cycle as expiry wins
      active_r <= 1'b1; // RL9
      seen_r <= 1'b1;
      pend_r <= mapped; // RL18
    end else if (expired) begin
      // Display falls to zero duty at the next wrap
      active_r <= 1'b0; // RL10 RL12
    end
  end
  // Step and period counters, 40 steps of 0.208 ms
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step_cnt_r <= 32'h0;
      step_r <= 6'h00;
      duty_r <= 6'h00;
    end else if (step_tick) begin
      step_cnt_r <= 32'h0;
      // Duty loads only at the wrap, so no period is cut short
      if (step_r == LAST_STEP) begin // RL4 RL5
        step_r <= 6'h00;
        duty_r <= active_r ? pend_r : 6'h00; // RL18 RL10
      end else begin
        step_r <= step_r + 6'h01;
      end
    end else begin
      // Count cycles inside the step
      step_cnt_r <= step_cnt_r + 32'h1;
    end
  end
  // Pin level: high for duty steps at start of each period
  // Registered, so the pin moves one cycle after the step count
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out_r <= 1'b0;
    end else begin
      pin_out_r <= high_now; // RL5 RL14
    end
  end
endmodule // rpw_indicator

// File: bench/rpw_indicator_asserts.sv
module rpw_chk #(
  parameter UNIT_CYC = 20,
  parameter STEP_CYC = 4
) (
  input wire clk,
  input wire resetn,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_wdata,
  input wire cmd_rvalid_r,
  input wire [7:0] cmd_rdata_r,
  input wire pin_out_r,
  input wire pin_oe_r,
  input wire [7:0] hold_time_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Cycles since reset, current high run, cycles since last rise
  int up_cnt;
  int hi_cnt;
  int gap;
  // Read and accepted-write requests
  wire rd = cmd_valid && !cmd_write && cmd_code == 8'h22;
  wire wr = cmd_valid && cmd_write && cmd_code == 8'h22 && (cmd_wdata < 8'h80 || &cmd_wdata);
  sequence s_zero2;
    hold_time_r == 8'h00 [*2];
  endsequence
  // Helper counters
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_cnt <= 0;
      hi_cnt <= 0;
      gap <= 0;
    end else begin
      up_cnt <= up_cnt < 100000 ? up_cnt + 1 : up_cnt;
      hi_cnt <= pin_out_r ? hi_cnt + 1 : 0;
      gap <= $rose(pin_out_r) ? 1 : (gap != 0 ? gap + 1 : 0);
    end
  end
  a_read_answer: assert property (rd |=> cmd_rvalid_r && cmd_rdata_r == $past(hold_time_r))
    else $error("read answer wrong");
  a_no_answer: assert property (!rd |=> !cmd_rvalid_r)
    else $error("answer without read");
  a_write_take: assert property (wr |=> hold_time_r == $past(cmd_wdata))
    else $error("hold write lost");
  a_write_refuse: assert property (!wr |=> $stable(hold_time_r))
    else $error("hold changed");
  a_zero_off: assert property (s_zero2 |-> !pin_oe_r)
    else $error("pin driven with zero hold");
  a_drive_low: assert property ($rose(pin_oe_r) |-> !pin_out_r)
    else $error("pin not low when driven");
  a_input_start: assert property (pin_oe_r |-> up_cnt >= UNIT_CYC)
    else $error("pin driven too early");
  a_high_limit: assert property (hi_cnt <= 38 * STEP_CYC)
    else $error("high time too long");
  a_whole_steps: assert property ($fell(pin_out_r) |-> hi_cnt % STEP_CYC == 0)
    else $error("high time not whole steps");
  a_period_len: assert property ($rose(pin_out_r) && gap != 0 |-> gap % (40 * STEP_CYC) == 0)
    else $error("period wrong");
endmodule // rpw_chk
bind rpw_indicator rpw_chk #(.UNIT_CYC(UNIT_CYC), .STEP_CYC(STEP_CYC)) u_rpw_chk (.*);

// File: bench/rpw_host.sv
module rpw_host (
  input wire clk,
  input wire pin_oe_r,
  input wire pin_out_r,
  input wire strap_low,
  output wire pin,
  output int high_cyc,
  output int idle
);
  timeunit 1ns;
  timeprecision 1ps;
  int run;
  // Released pin is pulled up; strap pulls it low only while held
  assign pin = pin_oe_r ? pin_out_r : !strap_low;
  // Last high run length and cycles since last driven high
  always @(posedge clk) begin
    if (pin_oe_r && pin_out_r) begin
      run <= run + 1;
      idle <= 0;
    end else begin
      if (run != 0) high_cyc <= run;
      run <= 0;
      idle <= idle + 1;
    end
  end
endmodule // rpw_host

// File: bench/rpw_indicator_test.sv
module rpw_indicator_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0;
  logic pkt_valid = 1'b0, strap_low = 1'b1;
  logic [7:0] cmd_code = 8'h00, cmd_wdata = 8'h00, pkt_code = 8'h06;
  wire cmd_rvalid_r, pin_out_r, pin_oe_r, cmd_mode_r, pin;
  wire [7:0] cmd_rdata_r, hold_time_r;
  int high_cyc, idle, fail_count = 0, num_checks = 0;
  `define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value at %0t got %h expected %h", $time, g, e); end end
  rpw_indicator #(.UNIT_CYC(20), .STEP_CYC(4)) u_rpw_indicator (.clk(clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rvalid_r(cmd_rvalid_r), .cmd_rdata_r(cmd_rdata_r), .pkt_valid(pkt_valid),
    .pkt_code(pkt_code), .pin_in(pin), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r),
    .cmd_mode_r(cmd_mode_r), .hold_time_r(hold_time_r));
  rpw_host u_rpw_host (.clk(clk), .pin_oe_r(pin_oe_r), .pin_out_r(pin_out_r),
    .strap_low(strap_low), .pin(pin), .high_cyc(high_cyc), .idle(idle));
  initial forever #5 clk = ~clk;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One command; a read checks the answer against d
  task automatic cmd(input logic w, input logic [7:0] c, d);
    {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, w, c, d};
    step(1);
    if (!w) begin
      `CHK(cmd_rvalid_r, 1'b1)
      `CHK(cmd_rdata_r, d)
    end
    cmd_valid = 1'b0;
    step(1);
  endtask
  task automatic pkt(input logic [7:0] c);
    {pkt_valid, pkt_code} = {1'b1, c};
    step(1);
    pkt_valid = 1'b0;
  endtask
  task automatic t_boot;
    step(10);
    strap_low = 1'b0;
    `CHK(cmd_mode_r, 1'b1)
    `CHK(pin_oe_r, 1'b0)
    cmd(1'b0, 8'h22, 8'h00);
  endtask
  task automatic t_write;
    cmd(1'b1, 8'h22, 8'h80);
    cmd(1'b0, 8'h22, 8'h00);
    cmd(1'b1, 8'h12, 8'h05);
    cmd(1'b0, 8'h22, 8'h00);
    cmd(1'b1, 8'h22, 8'h09);
    cmd(1'b0, 8'h22, 8'h09);
    `CHK(hold_time_r, 8'h09)
  endtask
  task automatic t_run;
    `CHK(pin_oe_r, 1'b0)
    pkt(8'h24);
    for (int i = 0; i < 300 && !pin_oe_r; i++) step(1);
    `CHK(pin_oe_r, 1'b1)
    step(200);
    `CHK(idle >= 200, 1'b1)
  endtask
  task automatic t_map;
    logic [7:0] code[5] = '{8'h10, 8'h1a, 8'h24, 8'h36, 8'h06};
    int hi[5] = '{19, 25, 31, 38, 0};
    cmd(1'b1, 8'h22, 8'hff);
    for (int i = 0; i < 5; i++) begin
      pkt(code[i]);
      step(400);
      if (hi[i] == 0) `CHK(idle >= 160, 1'b1)
      else `CHK(high_cyc, hi[i] * 4)
    end
  endtask
  task automatic t_expire;
    cmd(1'b1, 8'h22, 8'h09);
    pkt(8'h24);
    step(800);
    `CHK(high_cyc, 124)
    `CHK(idle >= 300, 1'b1)
    cmd(1'b1, 8'h22, 8'h00);
    step(3);
    `CHK(pin_oe_r, 1'b0)
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    step(4);
    resetn = 1'b1;
    t_boot();
    t_write();
    t_run();
    t_map();
    t_expire();
    report_and_stop();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule // rpw_indicator_test
